//--- hw/orient_consts.vh
// Constants for the orientation settle and trip-angle block.
`ifndef ORIENT_CONSTS_VH
`define ORIENT_CONSTS_VH

// Register indices; the byte address is four times the index.
`define IDX_STATE          8'h28
`define IDX_SETUP          8'h29
`define IDX_SETTLE_COUNT   8'h2A
`define IDX_BF_TILT        8'h2B
`define IDX_TRIP_ANGLES    8'h2C
`define IDX_IRQ_STATUS     8'h2D
`define IDX_IRQ_MASK       8'h2E

// Reset values.
`define RST_SETUP          8'h80
`define RST_SETTLE_COUNT   8'h00
`define RST_BF_TILT        8'h44
`define RST_TRIP_ANGLES    8'h84
`define RST_IRQ_MASK       8'h00

// Field positions.
`define SETUP_MODE_BIT     7
`define SETUP_ENABLE_BIT   6
`define BF_HI              7
`define BF_LO              6
`define LOCK_HI            2
`define LOCK_LO            0
`define THS_HI             7
`define THS_LO             3
`define HYS_HI             2
`define HYS_LO             0
`define STATE_FLAG_BIT     7
`define STATE_LOCK_BIT     6

// Back/front limits in degrees for code 00 and the narrowing per code step.
`define BF_FRONT_LOW       9'd80
`define BF_FRONT_HIGH      9'd280
`define BF_BACK_LOW        9'd100
`define BF_BACK_HIGH       9'd260
`define BF_STEP            9'd5

// AXI responses.
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

//--- hw/orientation_debounce_thresholds.v
// Orientation settle counter, trip-angle decisions and AXI4-Lite register file.
// Behaviour
// - Flag changes only after settle-count samples of persistence; first detection flags at once
// - Counter advances once per output sample
// - Counter resets on standby/active or wake/sleep change
// - Counter frozen while any axis above 1.25 g
// - Mode bit: differing orientation decrements or clears
// - Two-bit back/front field, bits 7:6, default 01
// - Back/front limits narrow five degrees per code
// - Three-bit lockout field, bits 2:0, default 100
// - Five-bit threshold field decoded through angle table
// - Hysteresis field widens trip angles around threshold
// - Classify portrait/landscape up/down/right/left by axis signs
// - Report result as two-bit orientation code
// - Flag on first detection, changes; read clears
`timescale 1ns/1ps
`include "orient_consts.vh"

module orientation_debounce_thresholds (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // AXI4-Lite write address and data
    input  wire [7:0]  s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output reg         s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output reg         s_axi_wready_o,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp_o,
    output reg         s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output reg         s_axi_arready_o,
    output reg  [31:0] s_axi_rdata_o,
    output reg  [1:0]  s_axi_rresp_o,
    output reg         s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    // Sample stream from the angle datapath
    input  wire        sample_i,
    input  wire        high_g_i,
    input  wire        accel_x_neg_i,
    input  wire        accel_y_neg_i,
    input  wire [9:0]  lp_angle_i,
    input  wire [9:0]  z_tilt_i,
    input  wire [8:0]  z_angle_i,
    // Operating state
    input  wire        active_i,
    input  wire        wake_i,
    // Results
    output reg  [1:0]  landscape_portrait_code_o,
    output reg         back_front_code_o,
    output reg         tilt_lockout_flag_o,
    output reg         orientation_changed_flag_o,
    output reg         irq_o
);

    // Register file.
    reg  [7:0]  orientation_setup_register;
    reg  [7:0]  orientation_settle_count;
    reg  [7:0]  orientation_backfront_tilt_limits;
    reg  [7:0]  orientation_trip_angles;
    reg  [7:0]  irq_mask;
    reg         irq_status;

    // Orientation state.
    reg  [7:0]  settle_counter;
    reg  [3:0]  prev_cand;
    reg         first_pending;
    reg         active_q;
    reg         wake_q;

    // AXI write capture.
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [7:0]  w_data;
    reg         w_lane0;

    wire        settle_counter_mode    = orientation_setup_register[`SETUP_MODE_BIT];
    wire        orient_enable          = orientation_setup_register[`SETUP_ENABLE_BIT];
    wire [1:0]  back_front_trip_angle  = orientation_backfront_tilt_limits[`BF_HI:`BF_LO];
    wire [2:0]  tilt_lockout_angle     = orientation_backfront_tilt_limits[`LOCK_HI:`LOCK_LO];
    wire [4:0]  landscape_portrait_threshold = orientation_trip_angles[`THS_HI:`THS_LO];
    wire [2:0]  trip_hysteresis        = orientation_trip_angles[`HYS_HI:`HYS_LO];

    // Threshold angle in tenths of a degree; code 00h sits in the lowest ten bits.
    localparam [319:0] THS_TABLE = {
        10'd882, 10'd862, 10'd841, 10'd819, 10'd795, 10'd770, 10'd744, 10'd716,
        10'd686, 10'd656, 10'd624, 10'd590, 10'd556, 10'd521, 10'd486, 10'd450,
        10'd414, 10'd379, 10'd344, 10'd310, 10'd276, 10'd244, 10'd214, 10'd184,
        10'd156, 10'd130, 10'd105, 10'd81,  10'd59,  10'd38,  10'd18,  10'd0
    };
    wire [9:0]  ths_tenths = THS_TABLE[landscape_portrait_threshold * 10 +: 10];

    // Hysteresis offset and lockout minimum angle in tenths of a degree.
    reg  [9:0]  hys_tenths;
    reg  [9:0]  lock_tenths;
    always @*
    begin
        case (trip_hysteresis)
            3'd0: hys_tenths = 10'd0;
            3'd1: hys_tenths = 10'd40;
            3'd2: hys_tenths = 10'd70;
            3'd3: hys_tenths = 10'd110;
            3'd4: hys_tenths = 10'd140;
            3'd5: hys_tenths = 10'd170;
            3'd6: hys_tenths = 10'd210;
            default: hys_tenths = 10'd240;
        endcase
        case (tilt_lockout_angle)
            3'd0: lock_tenths = 10'd136;
            3'd1: lock_tenths = 10'd171;
            3'd2: lock_tenths = 10'd207;
            3'd3: lock_tenths = 10'd244;
            3'd4: lock_tenths = 10'd281;
            3'd5: lock_tenths = 10'd320;
            3'd6: lock_tenths = 10'd361;
            default: lock_tenths = 10'd404;
        endcase
    end

    // Candidate orientation from the present sample.
    wire [10:0] trip_up   = {1'b0, ths_tenths} + {1'b0, hys_tenths};
    wire [9:0]  trip_down = (ths_tenths > hys_tenths) ? (ths_tenths - hys_tenths) : 10'd0;
    wire        is_landscape = landscape_portrait_code_o[1];
    wire        next_portrait = is_landscape ? ({1'b0, lp_angle_i} > trip_up)
                                             : (lp_angle_i >= trip_down);
    wire [1:0]  cand_landscape_portrait_code = next_portrait ? {1'b0, ~accel_y_neg_i} : {1'b1, accel_x_neg_i};

    wire [8:0]  bf_shift = {7'd0, back_front_trip_angle} * `BF_STEP;
    wire        to_front = (z_angle_i < (`BF_FRONT_LOW - bf_shift)) ||
                           (z_angle_i > (`BF_FRONT_HIGH + bf_shift));
    wire        to_back  = (z_angle_i > (`BF_BACK_LOW + bf_shift)) &&
                           (z_angle_i < (`BF_BACK_HIGH - bf_shift));
    wire        cand_back_front_code = back_front_code_o ? ~to_front : to_back;
    wire        cand_lo    = (z_tilt_i < lock_tenths);
    wire [3:0]  cand       = {cand_lo, cand_back_front_code, cand_landscape_portrait_code};
    wire [3:0]  reported   = {tilt_lockout_flag_o, back_front_code_o, landscape_portrait_code_o};

    wire        mode_change = (active_i != active_q) || (wake_i != wake_q);
    wire        eval        = sample_i && active_i && orient_enable && !high_g_i;
    wire [8:0]  count_next  = {1'b0, settle_counter} + 9'd1;
    wire        settled     = (count_next > {1'b0, orientation_settle_count});
    wire        commit      = eval && !mode_change &&
                              (first_pending || ((cand != reported) && (cand == prev_cand) && settled));

    // AXI decode.
    wire        wr_fire = aw_held && w_held && !s_axi_bvalid_o;
    wire        rd_fire = s_axi_arvalid_i && s_axi_arready_o;
    wire [5:0]  rd_idx  = s_axi_araddr_i[7:2];
    wire [5:0]  wr_idx  = aw_addr[7:2];
    wire        rd_state = rd_fire && ({2'b00, rd_idx} == `IDX_STATE);
    wire        rd_irq   = rd_fire && ({2'b00, rd_idx} == `IDX_IRQ_STATUS);

    reg  [7:0]  rd_byte;
    reg         rd_ok;
    always @*
    begin
        rd_ok = 1'b1;
        case ({2'b00, rd_idx})
            `IDX_STATE:        rd_byte = {orientation_changed_flag_o, tilt_lockout_flag_o, 3'b000,
                                          landscape_portrait_code_o, back_front_code_o};
            `IDX_SETUP:        rd_byte = orientation_setup_register;
            `IDX_SETTLE_COUNT: rd_byte = orientation_settle_count;
            `IDX_BF_TILT:      rd_byte = orientation_backfront_tilt_limits;
            `IDX_TRIP_ANGLES:  rd_byte = orientation_trip_angles;
            `IDX_IRQ_STATUS:   rd_byte = {7'd0, irq_status};
            `IDX_IRQ_MASK:     rd_byte = irq_mask;
            default:
            begin
                rd_byte = 8'h00;
                rd_ok   = 1'b0;
            end
        endcase
    end

    reg         wr_ok;
    always @*
    begin
        case ({2'b00, wr_idx})
            `IDX_STATE, `IDX_SETUP, `IDX_SETTLE_COUNT, `IDX_BF_TILT,
            `IDX_TRIP_ANGLES, `IDX_IRQ_STATUS, `IDX_IRQ_MASK: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    // AXI handshakes and configuration registers.
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= `RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rresp_o   <= `RESP_OKAY;
            s_axi_rdata_o   <= 32'h0000_0000;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 8'h00;
            w_lane0 <= 1'b0;
            orientation_setup_register        <= `RST_SETUP;
            orientation_settle_count          <= `RST_SETTLE_COUNT;
            orientation_backfront_tilt_limits <= `RST_BF_TILT;
            orientation_trip_angles           <= `RST_TRIP_ANGLES;
            irq_mask <= `RST_IRQ_MASK;
        end
        else
        begin
            s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o) && !s_axi_bvalid_o;
            s_axi_wready_o  <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o) && !s_axi_bvalid_o;
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_held  <= 1'b1;
                w_data  <= s_axi_wdata_i[7:0];
                w_lane0 <= s_axi_wstrb_i[0];
            end
            if (wr_fire)
            begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                if (w_lane0)
                begin
                    case ({2'b00, wr_idx})
                        `IDX_SETUP:        orientation_setup_register        <= w_data;
                        `IDX_SETTLE_COUNT: orientation_settle_count          <= w_data;
                        `IDX_BF_TILT:      orientation_backfront_tilt_limits <= w_data;
                        `IDX_TRIP_ANGLES:  orientation_trip_angles           <= w_data;
                        `IDX_IRQ_MASK:     irq_mask                          <= w_data;
                        default:           irq_mask                          <= irq_mask;
                    endcase
                end
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
            begin
                s_axi_bvalid_o <= 1'b0;
            end
            s_axi_arready_o <= !s_axi_rvalid_o && !rd_fire;
            if (rd_fire)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o  <= {24'h00_0000, rd_byte};
                s_axi_rresp_o  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
            begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // Settle counter, reported orientation, flag and interrupt.
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            settle_counter             <= 8'h00;
            prev_cand                  <= 4'h0;
            first_pending              <= 1'b1;
            active_q                   <= 1'b0;
            wake_q                     <= 1'b0;
            landscape_portrait_code_o  <= 2'b00;
            back_front_code_o          <= 1'b0;
            tilt_lockout_flag_o        <= 1'b0;
            orientation_changed_flag_o <= 1'b0;
            irq_status                 <= 1'b0;
            irq_o                      <= 1'b0;
        end
        else
        begin
            active_q <= active_i;
            wake_q   <= wake_i;
            if (mode_change)
            begin
                settle_counter <= 8'h00;
                if (active_i && !active_q)
                begin
                    first_pending             <= 1'b1;
                    landscape_portrait_code_o <= 2'b00;
                    back_front_code_o         <= 1'b0;
                end
            end
            else if (eval)
            begin
                prev_cand <= cand;
                if (commit)
                begin
                    {tilt_lockout_flag_o, back_front_code_o, landscape_portrait_code_o} <= cand;
                    settle_counter <= 8'h00;
                    first_pending  <= 1'b0;
                end
                else if (cand != prev_cand)
                begin
                    if (settle_counter_mode)
                        settle_counter <= 8'h00;
                    else if (settle_counter != 8'h00)
                        settle_counter <= settle_counter - 8'h01;
                end
                else if (cand != reported)
                begin
                    settle_counter <= count_next[7:0];
                end
                else
                begin
                    settle_counter <= 8'h00;
                end
            end
            // A set in the same cycle as a clearing read wins.
            if (commit)
                orientation_changed_flag_o <= 1'b1;
            else if (rd_state)
                orientation_changed_flag_o <= 1'b0;
            if (commit)
                irq_status <= 1'b1;
            else if (rd_irq)
                irq_status <= 1'b0;
            irq_o <= (irq_status || commit) && irq_mask[0];
        end
    end

endmodule // orientation_debounce_thresholds

//--- bench/orient_props.sv
// Checker for sample gating, settle freeze and register-bus timing of the orientation block.
`timescale 1ns/1ps
module orient_props (
    // Clock and reset
    input logic        clk_i,
    input logic        rst_i,
    // Register bus
    input logic [7:0]  s_axi_araddr_i,
    input logic        s_axi_arvalid_i,
    input logic        s_axi_arready_o,
    input logic [31:0] s_axi_rdata_o,
    input logic [1:0]  s_axi_rresp_o,
    input logic        s_axi_rvalid_o,
    input logic        s_axi_rready_i,
    input logic [1:0]  s_axi_bresp_o,
    input logic        s_axi_bvalid_o,
    input logic        s_axi_bready_i,
    // Sample stream and results
    input logic        sample_i,
    input logic        high_g_i,
    input logic        active_i,
    input logic [1:0]  landscape_portrait_code_o,
    input logic        back_front_code_o,
    input logic        tilt_lockout_flag_o,
    input logic        orientation_changed_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [3:0] res     = {landscape_portrait_code_o, back_front_code_o, tilt_lockout_flag_o};
    wire       rd_take = s_axi_arvalid_i && s_axi_arready_o;
    sequence s_state_take;
        rd_take && s_axi_araddr_i == 8'hA0 && !sample_i;
    endsequence
    sequence s_quiet2;
        !sample_i [*2];
    endsequence
    AST_HOLD_NO_SAMPLE: assert property (!sample_i && $stable(active_i) |=> $stable(res))
        else $error("orientation result moved without a sample");
    AST_FREEZE_HIGH_G: assert property (sample_i && high_g_i && $stable(active_i) |=> $stable(res))
        else $error("orientation result moved under high acceleration");
    AST_ACTIVATE_CLEARS: assert property ($rose(active_i) |=> res[3:1] == 3'h0)
        else $error("codes not cleared on activation");
    AST_FLAG_ON_SAMPLE: assert property ($rose(orientation_changed_flag_o) |-> $past(sample_i))
        else $error("change flag rose without a sample");
    AST_READ_CLEARS_FLAG: assert property (s_state_take ##1 s_quiet2 |=> !orientation_changed_flag_o)
        else $error("state read did not clear change flag");
    AST_READ_ANSWER: assert property (rd_take |=> s_axi_rvalid_o)
        else $error("read answer late");
    AST_RVALID_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read answer dropped before taken");
    AST_BVALID_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write answer dropped before taken");
    AST_UNMAPPED_READ: assert property (rd_take && (s_axi_araddr_i < 8'hA0 || s_axi_araddr_i > 8'hBB)
        |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule // orient_props
bind orientation_debounce_thresholds orient_props u_props (.*);

//--- bench/orientation_debounce_thresholds_tb.sv
// Self-checking bench for the orientation settle and trip-angle block.
`timescale 1ns/1ps
module orientation_debounce_thresholds_tb;
    logic        clk_i = 1'h0, rst_i = 1'h1;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, prev = 8'hFF, rnd;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o;
    logic [3:0]  s_axi_wstrb_i = 4'hF;
    logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic        s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, landscape_portrait_code_o;
    logic        back_front_code_o, tilt_lockout_flag_o, orientation_changed_flag_o, irq_o;
    logic        sample_i = 1'h0, high_g_i = 1'h0, accel_x_neg_i = 1'h0, accel_y_neg_i = 1'h1;
    logic        active_i = 1'h0, wake_i = 1'h0;
    logic [9:0]  lp_angle_i = 10'h000, z_tilt_i = 10'h1F4;
    logic [8:0]  z_angle_i = 9'h01E;
    logic [33:0] exp_q [$];
    logic [1:0]  bexp_q [$];
    int          n_errors = 0, check_count = 0, i, k;
    // Table rows: register written, value, XY angle, tilt, expected state bits.
    logic [7:0]  ra [13] = '{8'hB0, 8'hB0, 8'hB0, 8'hB0, 8'hB0, 8'hB0, 8'hB0, 8'hB0, 8'hAC, 8'hAC, 8'hAC, 8'hAC, 8'hAC};
    logic [7:0]  rv [13] = '{8'h80, 8'h80, 8'h87, 8'h87, 8'h87, 8'h87, 8'hF8, 8'hF8, 8'h40, 8'h47, 8'h47, 8'h44, 8'h44};
    logic [9:0]  la [13] = '{10'h1CC, 10'h1B8, 10'h258, 10'h2BC, 10'h12C, 10'h0C8, 10'h366, 10'h37A,
                            10'h37A, 10'h37A, 10'h37A, 10'h37A, 10'h37A};
    logic [9:0]  za [13] = '{10'h1F4, 10'h1F4, 10'h1F4, 10'h1F4, 10'h1F4, 10'h1F4, 10'h1F4, 10'h1F4,
                            10'h096, 10'h096, 10'h1A4, 10'h10E, 10'h1F4};
    logic [6:0]  sa [13] = '{7'h00, 7'h06, 7'h06, 7'h00, 7'h00, 7'h06, 7'h06, 7'h00, 7'h00, 7'h40, 7'h00, 7'h40, 7'h00};

    orientation_debounce_thresholds u_dut (.*);

    always #2 clk_i = ~clk_i;

    task automatic finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
        begin
            check_count++;
            if (g !== e)
            begin
                n_errors++;
                $display("[ERR] %s expected %h seen %h", what, e, g);
            end
        end
    endtask

    task automatic hang;
        begin
            n_errors++;
            $display("[ERR] handshake expected answer seen none");
            finish_test();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        begin
            bexp_q.push_back(r);
            s_axi_awaddr_i  <= a;
            s_axi_wdata_i   <= {24'h00_0000, d};
            s_axi_awvalid_i <= 1'h1;
            s_axi_wvalid_i  <= 1'h1;
            for (n = 0; n < 60; n++)
            begin
                @(posedge clk_i);
                if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
                if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
                if (s_axi_bvalid_o && s_axi_bready_i) break;
                if (s_axi_bvalid_o) s_axi_bready_i <= 1'h1;
            end
            s_axi_bready_i <= 1'h0;
            if (n == 60) hang();
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] r, input logic [7:0] d);
        int n;
        begin
            exp_q.push_back({r, 24'h00_0000, d});
            s_axi_araddr_i  <= a;
            s_axi_arvalid_i <= 1'h1;
            for (n = 0; n < 60; n++)
            begin
                @(posedge clk_i);
                if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
                if (s_axi_rvalid_o && s_axi_rready_i) break;
                if (s_axi_rvalid_o) s_axi_rready_i <= 1'h1;
            end
            s_axi_rready_i <= 1'h0;
            if (n == 60) hang();
        end
    endtask

    task automatic pulse(input logic hg);
        begin
            high_g_i <= hg;
            sample_i <= 1'h1;
            @(posedge clk_i);
            sample_i <= 1'h0;
            high_g_i <= 1'h0;
            @(posedge clk_i);
        end
    endtask

    // The change flag is expected whenever the reported bits differ from the last read.
    task automatic expect_state(input logic [6:0] st);
        begin
            chk("result pins", st, {tilt_lockout_flag_o, 3'h0, landscape_portrait_code_o, back_front_code_o});
            chk("flag pin", st != prev, orientation_changed_flag_o);
            axi_rd(8'hA0, 2'h0, {st != prev, st});
            prev = st;
        end
    endtask

    always @(posedge clk_i)
        if (s_axi_rvalid_o && s_axi_rready_i)
        begin
            if (exp_q.size() == 0)
                chk("unexpected read", 34'h0, 34'h1);
            else
                chk("read", exp_q.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
        end

    always @(posedge clk_i)
        if (s_axi_bvalid_o && s_axi_bready_i)
        begin
            if (bexp_q.size() == 0)
                chk("unexpected write answer", 34'h0, 34'h1);
            else
                chk("bresp", bexp_q.pop_front(), s_axi_bresp_o);
        end

    initial
    begin
        void'($urandom(32'he1c3_7c52));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        axi_rd(8'hA4, 2'h0, 8'h80);
        axi_rd(8'hA8, 2'h0, 8'h00);
        axi_rd(8'hAC, 2'h0, 8'h44);
        axi_rd(8'hB0, 2'h0, 8'h84);
        axi_rd(8'hB8, 2'h0, 8'h00);
        axi_rd(8'h00, 2'h2, 8'h00);
        axi_wr(8'h04, 8'h5A, 2'h2);
        rnd = 8'($urandom);
        axi_wr(8'hA8, rnd, 2'h0);
        axi_rd(8'hA8, 2'h0, rnd);
        axi_wr(8'hA8, 8'h00, 2'h0);
        axi_wr(8'hA4, 8'hC0, 2'h0);
        $display("register test done");
        active_i <= 1'h1;
        @(posedge clk_i);
        pulse(1'h0);
        expect_state(7'h04);
        axi_rd(8'hB4, 2'h0, 8'h01);
        axi_rd(8'hB4, 2'h0, 8'h00);
        chk("irq", 1'h0, irq_o);
        axi_wr(8'hB8, 8'h01, 2'h0);
        accel_x_neg_i <= 1'h1;
        // A differing sample restarts the count, so even a zero settle count needs two matching samples.
        repeat (2) pulse(1'h0);
        repeat (2) @(posedge clk_i);
        chk("irq", 1'h1, irq_o);
        expect_state(7'h06);
        axi_rd(8'hB4, 2'h0, 8'h01);
        repeat (2) @(posedge clk_i);
        chk("irq", 1'h0, irq_o);
        $display("activation and interrupt test done");
        for (i = 0; i < 13; i++)
        begin
            axi_wr(ra[i], rv[i], 2'h0);
            lp_angle_i <= la[i];
            z_tilt_i   <= za[i];
            repeat (2) pulse(1'h0);
            expect_state(sa[i]);
        end
        $display("trip angle and lockout test done");
        for (k = 0; k < 4; k++)
        begin
            axi_wr(8'hAC, {k[1:0], 6'h04}, 2'h0);
            z_angle_i <= 9'(100 + 5 * k);
            repeat (2) pulse(1'h0);
            expect_state(7'h00);
            z_angle_i <= 9'(101 + 5 * k);
            repeat (2) pulse(1'h0);
            expect_state(7'h01);
            z_angle_i <= 9'(80 - 5 * k);
            repeat (2) pulse(1'h0);
            expect_state(7'h01);
            z_angle_i <= 9'(79 - 5 * k);
            repeat (2) pulse(1'h0);
            expect_state(7'h00);
        end
        $display("back front test done");
        axi_wr(8'hA8, 8'h03, 2'h0);
        lp_angle_i <= 10'h000;
        repeat (3) pulse(1'h0);
        pulse(1'h1);
        pulse(1'h0);
        expect_state(7'h00);
        pulse(1'h0);
        expect_state(7'h06);
        lp_angle_i <= 10'h37A;
        repeat (2) pulse(1'h0);
        wake_i <= 1'h1;
        @(posedge clk_i);
        repeat (3) pulse(1'h0);
        expect_state(7'h06);
        pulse(1'h0);
        expect_state(7'h00);
        lp_angle_i <= 10'h000;
        repeat (4) pulse(1'h0);
        accel_x_neg_i <= 1'h0;
        pulse(1'h0);
        accel_x_neg_i <= 1'h1;
        repeat (4) pulse(1'h0);
        expect_state(7'h00);
        pulse(1'h0);
        expect_state(7'h06);
        axi_wr(8'hA4, 8'h40, 2'h0);
        lp_angle_i <= 10'h37A;
        repeat (4) pulse(1'h0);
        accel_y_neg_i <= 1'h0;
        pulse(1'h0);
        accel_y_neg_i <= 1'h1;
        repeat (3) pulse(1'h0);
        expect_state(7'h06);
        pulse(1'h0);
        expect_state(7'h00);
        $display("settle counter test done");
        finish_test();
    end
endmodule // orientation_debounce_thresholds_tb
